// file: rtl/hbi_pkg.sv
// hbi_pkg: constants and carrier types of the host bus interface block
//
// Summary of operation
// - only ten of twenty-four address lines are decoded, card within 000..3FF
// - board enable needs address bits 5..9 matching the base and an active read or write strobe
// - address bits 0..4 form the register select toward board units
// - address latched at cycle start, held for the decoder all cycle
// - data buffers drive the bus on reads, receive on writes
// - each transfer is 8 or 16 bits, strobes derived from bus timing
// - board reports access, ready for next transfer and transfer width
// - only enabled interrupt requests reach the chosen request line
// - interrupt outputs are three-state so the line can be shared
// - interrupt routed to at most one of eleven request lines, none for a select above 10
// - interrupt when at least one result waits in the converter FIFO
// - separate interrupt when the converter FIFO reaches half full
// - interrupt when acquisition ends, also on overflow or overrun
// - interrupt on terminal count pulse from the DMA controller
// - interrupt on falling edge of the converter update signal
// - each of five sources has its own enable and its own clear
// - with DMA on, request on available result and on converter update
// - DMA transfers are 16-bit on channel 5, 6 or 7
// - single-channel or dual-channel DMA mode is configurable
// - converter FIFO counted as 256 words; half full judged on that depth
// - overflow flagged when results beyond 256 arrive unread
`default_nettype none

package hbi_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ  = 25;
  localparam int unsigned WAIT_NS  = 120; // least not-ready time per cycle
  localparam int unsigned WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam int unsigned STAT_OVF    = 5;
  localparam int unsigned STAT_CNT_LSB = 8;
  localparam logic [4:0] FIFO_SEL     = 5'h00; // select of fifo data port
  localparam int unsigned NUM_SRC     = 5;
  localparam int unsigned NUM_IRQ     = 11;
  localparam int unsigned NUM_DMA     = 3;

  // interrupt source positions
  localparam int unsigned SRC_AVAIL = 0;
  localparam int unsigned SRC_HALF  = 1;
  localparam int unsigned SRC_DONE  = 2;
  localparam int unsigned SRC_TC    = 3;
  localparam int unsigned SRC_DAC   = 4;

  // control word, bit 0 is the lsb of irq_en
  typedef struct packed {
    logic [4:0] base;     // address bits 9..5 of the card
    logic [3:0] irq_line; // 0..10 = request lines 3-7, 9-12, 14, 15
    logic [1:0] dac_ch;   // 0..2 = dma channel 5..7, dual mode
    logic [1:0] adc_ch;   // 0..2 = dma channel 5..7
    logic       dual;
    logic       dma_en;
    logic [4:0] irq_en;
  } hbi_ctrl_s;

  localparam hbi_ctrl_s CTRL_RST = '0;

  // synchronised host pins
  typedef struct packed {
    logic        bale;
    logic        ior_n;
    logic        iow_n;
    logic        sbhe_n;
    logic        tc;
    logic [2:0]  dack_n;
    logic [9:0]  sa;
    logic [15:0] sd;
  } hbi_pins_s;

  // idle pin levels, so no false strobe or ack follows reset
  localparam hbi_pins_s PINS_RST = '{bale: 1'b0, ior_n: 1'b1, iow_n: 1'b1,
    sbhe_n: 1'b1, tc: 1'b0, dack_n: 3'h7, sa: 10'h000, sd: 16'h0000};

  // strobe bundle toward board units
  typedef struct packed {
    logic [4:0]  sel;
    logic        rd;
    logic        wr;
    logic        wide;
    logic [15:0] wdata;
  } hbi_unit_s;

endpackage : hbi_pkg

`default_nettype wire

// file: rtl/hbi_top.sv
// hbi_top: host bus interface with interrupt routing and dma requests
`default_nettype none

module hbi_top #(
  parameter int unsigned FIFO_DEPTH = 256
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [23:0]     sa,
  input  wire logic            bale,
  input  wire logic            ior_n,
  input  wire logic            iow_n,
  input  wire logic            sbhe_n,
  input  wire logic [15:0]     sd_in,
  output logic [15:0]          sd_out,
  output logic                 sd_oe,
  output logic                 board_sel,
  output logic                 io16_oe,
  output logic                 rdy_oe,
  output logic [10:0]          irq_o,
  output logic [10:0]          irq_oe,
  output logic [2:0]           drq,
  input  wire logic [2:0]      dack_n,
  input  wire logic            tc,
  output hbi_pkg::hbi_unit_s   unit,
  input  wire logic [15:0]     unit_rdata,
  input  wire logic            adc_push,
  input  wire logic            acq_done,
  input  wire logic            acq_err,
  input  wire logic            dac_upd_n
);
  import hbi_pkg::*;

  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 4096)
    $error("fifo depth out of range");
  if (WAIT_CYC < 1 || WAIT_CYC > 15)
    $error("wait count does not fit");

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    hbi_pins_s   p1;
    hbi_pins_s   p2;
    logic [2:0]  dk_d;
    logic        tc_d;
    logic        rd_d;
    logic        wr_d;
    logic        dac_d;
    logic [9:0]  addr;
    logic [3:0]  wcnt;
    hbi_ctrl_s   ctrl;
    logic [4:0]  flags;
    logic        ovf;
    logic [CW-1:0] cnt;
    logic        dac_pend;
    hbi_unit_s   unit;
    logic        board_sel;
    logic        sd_oe;
    logic [15:0] sd_out;
    logic        io16_oe;
    logic        rdy_oe;
    logic [10:0] irq_o;
    logic [10:0] irq_oe;
    logic [2:0]  drq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hbi_state_s;

  hbi_state_s st_reg;
  hbi_state_s st_next;
  hbi_pins_s  pin;
  hbi_pins_s  pin_in;

  logic            hit;
  logic            rd_act;
  logic            wr_act;
  logic            rd_start;
  logic            wr_start;
  logic            wide;
  logic            fifo_rd;
  logic            adc_ack;
  logic            dac_ack;
  logic            pop;
  logic            avail;
  logic            half;
  logic            ovf_ev;
  logic            dac_fall;
  logic            irq_req;
  logic [1:0]      dch;
  logic [2:0]      ack;
  logic [4:0]      src;
  logic            apb_acc;
  logic            apb_done;
  logic            mapped;

  // ****************************************
  // host pins, two stages before use
  // ****************************************
  assign pin_in = '{bale: bale, ior_n: ior_n, iow_n: iow_n,
                    sbhe_n: sbhe_n, tc: tc, dack_n: dack_n,
                    sa: sa[9:0], sd: sd_in};  // upper lines ignored
  assign pin = st_reg.p2;

  // ****************************************
  // decode and cycle detection
  // ****************************************
  assign hit      = st_reg.addr[9:5] == st_reg.ctrl.base;
  assign rd_act   = hit && !pin.ior_n;
  assign wr_act   = hit && !pin.iow_n;
  assign rd_start = rd_act && !st_reg.rd_d;
  assign wr_start = wr_act && !st_reg.wr_d;
  assign wide     = !pin.sbhe_n && !st_reg.addr[0];
  assign fifo_rd  = rd_start && st_reg.addr[4:0] == FIFO_SEL;

  // ****************************************
  // fifo occupancy and event sources
  // ****************************************
  assign avail    = st_reg.cnt != '0;
  assign half     = st_reg.cnt >= CW'(FIFO_DEPTH / 2);
  assign dch      = st_reg.ctrl.dual ? st_reg.ctrl.dac_ch
                                     : st_reg.ctrl.adc_ch;
  assign dac_fall = st_reg.dac_d && !dac_upd_n;
  assign ovf_ev   = adc_push && !pop && st_reg.cnt == CW'(FIFO_DEPTH);

  // dack falling edges per channel
  always_comb begin
    for (int i = 0; i < NUM_DMA; i++) begin
      ack[i] = st_reg.dk_d[i] && !pin.dack_n[i];
    end
  end

  // adc data wins a shared channel in single mode
  assign adc_ack = st_reg.ctrl.dma_en && avail &&
                   st_reg.ctrl.adc_ch != 2'h3 && ack[st_reg.ctrl.adc_ch];
  assign dac_ack = st_reg.dac_pend && dch != 2'h3 && ack[dch] &&
                   !(adc_ack && dch == st_reg.ctrl.adc_ch);
  assign pop     = (fifo_rd || adc_ack) && avail;

  assign src[SRC_AVAIL] = avail;
  assign src[SRC_HALF]  = half;
  assign src[SRC_DONE]  = acq_done || acq_err || ovf_ev;
  assign src[SRC_TC]    = pin.tc && !st_reg.tc_d;
  assign src[SRC_DAC]   = dac_fall;

  assign irq_req = |(st_reg.flags & st_reg.ctrl.irq_en);

  // ****************************************
  // apb decode
  // ****************************************
  assign apb_acc  = psel && penable && !st_reg.pready;
  assign apb_done = psel && penable && st_reg.pready;
  assign mapped   = paddr == OFS_CTRL || paddr == OFS_STAT;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    // synchronisers and edge history
    st_next.p1    = pin_in;
    st_next.p2    = st_reg.p1;
    st_next.dk_d  = pin.dack_n;
    st_next.tc_d  = pin.tc;
    st_next.rd_d  = rd_act;
    st_next.wr_d  = wr_act;
    st_next.dac_d = dac_upd_n;

    // address latch open while bale is high
    if (pin.bale) begin
      st_next.addr = pin.sa;
    end

    // unit strobes, one cycle each
    st_next.unit.sel  = st_reg.addr[4:0];
    st_next.unit.wide = wide;
    st_next.unit.rd   = rd_start;
    st_next.unit.wr   = st_reg.wr_d && !wr_act;
    if (wr_act) begin
      st_next.unit.wdata = pin.sd;
    end

    // bus answer signals
    st_next.board_sel = rd_act || wr_act;
    st_next.io16_oe   = hit && wide;
    st_next.sd_oe     = rd_act;
    st_next.sd_out    = rd_act ? unit_rdata : 16'h0000;

    // not-ready window at the start of each cycle
    if (rd_start || wr_start) begin
      st_next.wcnt = 4'(WAIT_CYC);
    end else if (st_reg.wcnt != 4'h0) begin
      st_next.wcnt = st_reg.wcnt - 4'h1;
    end
    st_next.rdy_oe = st_next.wcnt != 4'h0;

    // occupancy counter, overflow keeps the count
    if (adc_push && !pop && !ovf_ev) begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end else if (pop && !adc_push) begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end

    // sticky flags, software clear loses to a new event
    if (apb_done && pwrite && paddr == OFS_STAT) begin
      st_next.flags = st_reg.flags & ~pwdata[4:0];
      st_next.ovf   = st_reg.ovf & ~pwdata[STAT_OVF];
    end
    st_next.flags = st_next.flags | src;
    st_next.ovf   = st_next.ovf | ovf_ev;

    // converter update request
    st_next.dac_pend = (st_reg.dac_pend && !dac_ack) ||
                       (dac_fall && st_reg.ctrl.dma_en);

    // dma requests per channel
    for (int i = 0; i < NUM_DMA; i++) begin
      st_next.drq[i] = (st_reg.ctrl.dma_en && avail &&
                        st_reg.ctrl.adc_ch == 2'(i)) ||
                       (st_reg.dac_pend && dch == 2'(i));
    end

    // interrupt routing, one line driven at most
    for (int i = 0; i < NUM_IRQ; i++) begin
      st_next.irq_o[i]  = irq_req;
      st_next.irq_oe[i] = st_reg.ctrl.irq_line == 4'(i) &&
                          st_reg.ctrl.irq_en != 5'h00;
    end

    // apb slave, answer one cycle into the access phase
    st_next.pready  = apb_acc;
    st_next.pslverr = apb_acc && !mapped;
    if (apb_acc) begin
      case (paddr)
        OFS_CTRL: st_next.prdata = 32'(st_reg.ctrl);
        OFS_STAT: st_next.prdata = (32'(st_reg.cnt) << STAT_CNT_LSB) |
                                   (32'(st_reg.ovf) << STAT_OVF) |
                                   32'(st_reg.flags);
        default:  st_next.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_done && pwrite && paddr == OFS_CTRL) begin
      st_next.ctrl = hbi_ctrl_s'(pwdata[$bits(hbi_ctrl_s)-1:0]);
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '{p1: PINS_RST, p2: PINS_RST, dk_d: PINS_RST.dack_n,
                  dac_d: 1'b1, ctrl: CTRL_RST, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign sd_out    = st_reg.sd_out;
  assign sd_oe     = st_reg.sd_oe;
  assign board_sel = st_reg.board_sel;
  assign io16_oe   = st_reg.io16_oe;
  assign rdy_oe    = st_reg.rdy_oe;
  assign irq_o     = st_reg.irq_o;
  assign irq_oe    = st_reg.irq_oe;
  assign drq       = st_reg.drq;
  assign unit      = st_reg.unit;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cyc_start;
    rd_start || wr_start;
  endsequence

  sequence s_wait_win;
    rdy_oe [*3] ##1 !rdy_oe;
  endsequence

  property p_board_hit;
    board_sel |-> $past(st_reg.addr[9:5] == st_reg.ctrl.base);
  endproperty
  a_board_hit: assert property (p_board_hit)
    else $error("board selected without base match");

  property p_addr_hold;
    rd_act && !pin.bale |=> $stable(st_reg.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("latched address moved inside cycle");

  property p_dir;
    (rd_act |=> sd_oe) and (wr_act |=> !sd_oe);
  endproperty
  a_dir: assert property (p_dir)
    else $error("data buffer direction wrong");

  property p_ready;
    s_cyc_start |=> s_wait_win;
  endproperty
  a_ready: assert property (p_ready)
    else $error("not-ready window length wrong");

  property p_irq_one;
    $onehot0(irq_oe) and (st_reg.ctrl.irq_line > 4'hA |=> irq_oe == '0);
  endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("more than one request line driven");

  property p_irq_en;
    |(irq_o & irq_oe) |-> $past(irq_req);
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("request driven without enabled flag");

  property p_avail;
    st_reg.cnt != '0 |=> st_reg.flags[SRC_AVAIL];
  endproperty
  a_avail: assert property (p_avail)
    else $error("available flag missing");

  property p_tc;
    $rose(pin.tc) |=> st_reg.flags[SRC_TC];
  endproperty
  a_tc: assert property (p_tc)
    else $error("terminal count flag missing");

  property p_dac_edge;
    $fell(dac_upd_n) ##1 1'b1 |-> st_reg.flags[SRC_DAC];
  endproperty
  a_dac_edge: assert property (p_dac_edge)
    else $error("converter update flag missing");

  property p_ovf;
    ovf_ev |=> st_reg.ovf && st_reg.cnt == CW'(FIFO_DEPTH);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged at full depth");

  property p_dma_off;
    !st_reg.ctrl.dma_en && !$past(st_reg.ctrl.dma_en) &&
      !st_reg.dac_pend |=> drq == 3'h0;
  endproperty
  a_dma_off: assert property (p_dma_off)
    else $error("dma request while disabled");

endmodule : hbi_top

`default_nettype wire

// file: sim/hbi_host_model.sv
// hbi_host_model: host processor and dma controller seen from the card
`default_nettype none

module hbi_host_model (
  input  wire logic        clk,
  output logic [23:0]      sa,
  output logic             bale,
  output logic             ior_n,
  output logic             iow_n,
  output logic             sbhe_n,
  output logic [15:0]      sd_in,
  output logic [2:0]       dack_n,
  output logic             tc,
  input  wire logic        board_sel,
  input  wire logic        sd_oe,
  input  wire logic        io16_oe,
  input  wire logic        rdy_oe,
  input  wire logic [15:0] sd_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus: strobes and acks high
  initial begin
    sa     = '0;
    bale   = 1'b0;
    ior_n  = 1'b1;
    iow_n  = 1'b1;
    sbhe_n = 1'b1;
    sd_in  = 16'h0000;
    dack_n = 3'h7;
    tc     = 1'b0;
  end

  // one i/o cycle; seen = {board_sel, sd_oe, io16_oe, rdy_oe} ever high
  task automatic io(input logic w, input logic [9:0] a, input logic wide,
                    input logic [15:0] d, output logic [15:0] q,
                    output logic [3:0] seen);
    int i;
    seen = 4'h0;
    @(posedge clk);
    sa     <= {14'h2A5B, a}; // upper lines must be ignored
    bale   <= 1'b1;
    sbhe_n <= ~wide;
    repeat (2) @(posedge clk);
    bale <= 1'b0;
    @(posedge clk);
    sa <= ~sa; // card must keep its latched copy
    @(posedge clk); // width decode of the old address has settled
    if (w) begin
      iow_n <= 1'b0;
      sd_in <= d;
    end
    else
      ior_n <= 1'b0;
    // hold the strobe while the card pulls ready low
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      seen |= {board_sel, sd_oe, io16_oe, rdy_oe};
      if (seen[0] && !rdy_oe) break;
    end
    q = sd_out;
    ior_n <= 1'b1;
    iow_n <= 1'b1;
    repeat (4) @(posedge clk);
    sd_in <= ~d; // released bus shows no stale value
  endtask : io

  // one 16-bit dma transfer acknowledged on channel 5 + ch
  task automatic ack(input logic [1:0] ch);
    @(posedge clk) dack_n[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    dack_n <= 3'h7;
    repeat (3) @(posedge clk);
  endtask : ack

  // terminal count pulse
  task automatic tc_pulse;
    @(posedge clk) tc <= 1'b1;
    @(posedge clk) tc <= 1'b0;
  endtask : tc_pulse

endmodule : hbi_host_model

`default_nettype wire

// file: sim/hbi_top_tb.sv
// hbi_top_tb: apb and host pin testbench of the host bus interface
`default_nettype none

module hbi_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hbi_pkg::*;

  localparam int DEPTH = 8;
  localparam int CW    = $clog2(DEPTH + 1);
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        bale, ior_n, iow_n, sbhe_n, tc, sd_oe, board_sel, io16_oe;
  logic        rdy_oe, adc_push, acq_done, acq_err, dac_upd_n, rd_wide;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] sa;
  logic [15:0] sd_in, sd_out, unit_rdata, q, wr_dat;
  logic [10:0] irq_o, irq_oe;
  logic [2:0]  drq, dack_n;
  logic [3:0]  seen;
  logic [4:0]  rd_sel, wr_sel;
  hbi_unit_s   unit;
  hbi_ctrl_s   cw;
  int          fail_count, n_tests, s, i;

  hbi_top #(.FIFO_DEPTH(DEPTH)) dut_u (.clk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sa, .bale,
    .ior_n, .iow_n, .sbhe_n, .sd_in, .sd_out, .sd_oe, .board_sel,
    .io16_oe, .rdy_oe, .irq_o, .irq_oe, .drq, .dack_n, .tc, .unit,
    .unit_rdata, .adc_push, .acq_done, .acq_err, .dac_upd_n);

  hbi_host_model host_u (.clk, .sa, .bale, .ior_n, .iow_n, .sbhe_n,
    .sd_in, .dack_n, .tc, .board_sel, .sd_oe, .io16_oe, .rdy_oe, .sd_out);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // record what the board units were handed
  always @(posedge clk) begin
    if (unit.rd) begin
      rd_sel  <= unit.sel;
      rd_wide <= unit.wide;
    end
    if (unit.wr) begin
      wr_sel <= unit.sel;
      wr_dat <= unit.wdata;
    end
  end

  // ********
  // tasks
  // ********
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer, result left in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk("pready", 1, 0);
      finish_test;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wctl;
    apb(1'b1, OFS_CTRL, 32'(cw));
  endtask : wctl

  task automatic stat;
    apb(1'b0, OFS_STAT, 32'h0);
  endtask : stat

  task automatic rst;
    reset <= 1'b1;
    cyc(10);
    reset <= 1'b0;
    cyc(1);
  endtask : rst

  task automatic push(input int n);
    repeat (n) begin
      @(posedge clk) adc_push <= 1'b1;
      @(posedge clk) adc_push <= 1'b0;
    end
  endtask : push

  task automatic fire(input int s);
    case (s)
      0, 1: push(1);
      2: begin
        @(posedge clk) acq_done <= 1'b1;
        @(posedge clk) acq_done <= 1'b0;
      end
      3: host_u.tc_pulse;
      default: begin
        @(posedge clk) dac_upd_n <= 1'b0;
        @(posedge clk) dac_upd_n <= 1'b1;
      end
    endcase
  endtask : fire

  // ********
  // tests
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {adc_push, acq_done, acq_err} = '0;
    dac_upd_n  = 1'b1;
    unit_rdata = 16'hC35A;
    reset      = 1'b1;
    cw         = '0;
    rst;
    chk("irq_oe", 0, irq_oe);
    chk("drq", 0, drq);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk("unmapped", 1, err);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 0, rd);
    $display("test reset done");
    cw.base   = 5'h16;
    cw.irq_en = 5'h10;
    for (i = 0; i < 12; i++) begin
      cw.irq_line = 4'(i);
      wctl;
      cyc(3);
      chk("irq drive", (i < 11) ? (1 << i) : 0, irq_oe);
    end
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl back", 32'(cw), rd);
    cw.irq_en = 5'h00;
    cw.irq_line = 4'h0;
    wctl;
    cyc(3);
    chk("irq float", 0, irq_oe);
    $display("test lines done");
    host_u.io(1'b0, {5'h16, 5'h03}, 1'b1, 16'h0, q, seen);
    chk("read data", 16'hC35A, q);
    chk("odd read", 4'hD, seen);
    chk("read sel", 5'h03, rd_sel);
    chk("read width", 0, rd_wide);
    host_u.io(1'b0, {5'h16, 5'h02}, 1'b1, 16'h0, q, seen);
    chk("wide read", 4'hF, seen);
    chk("wide flag", 1, rd_wide);
    host_u.io(1'b1, {5'h16, 5'h07}, 1'b1, 16'h5AA5, q, seen);
    cyc(2);
    chk("write", 4'h9, seen);
    chk("write data", 16'h5AA5, wr_dat);
    chk("write sel", 5'h07, wr_sel);
    host_u.io(1'b0, {5'h06, 5'h03}, 1'b1, 16'h0, q, seen);
    chk("miss", 0, seen);
    $display("test host done");
    for (s = 0; s < 5; s++) begin
      rst;
      cw = '0;
      cw.irq_line = 4'h2;
      wctl;
      if (s == 1) begin
        push(DEPTH / 2 - 1);
        stat;
        chk("half early", 0, rd[1]);
      end
      fire(s);
      cyc(4);
      chk("masked irq", 0, irq_o[2]);
      stat;
      chk("flag", 1, rd[s]);
      cw.irq_en = 5'(1 << s);
      wctl;
      cyc(4);
      chk("irq on", 1, irq_o[2]);
      chk("irq line", 11'h004, irq_oe);
      if (s > 1) begin
        apb(1'b1, OFS_STAT, 32'(1 << s));
        cyc(4);
        chk("irq cleared", 0, irq_o[2]);
      end
    end
    $display("test sources done");
    rst;
    push(DEPTH);
    stat;
    chk("count full", DEPTH, rd[CW+7:8]);
    chk("no overflow", 0, rd[5]);
    push(1);
    stat;
    chk("count held", DEPTH, rd[CW+7:8]);
    chk("overflow", 1, rd[5]);
    chk("done on overflow", 1, rd[2]);
    apb(1'b1, OFS_STAT, 32'h24);
    @(posedge clk) acq_err <= 1'b1;
    @(posedge clk) acq_err <= 1'b0;
    stat;
    chk("done on overrun", 1, rd[2]);
    chk("overflow clear", 0, rd[5]);
    host_u.io(1'b0, 10'h000, 1'b1, 16'h0, q, seen);
    stat;
    chk("count after read", DEPTH - 1, rd[CW+7:8]);
    $display("test overflow done");
    rst;
    cw = '0;
    cw.dma_en = 1'b1;
    cw.dual   = 1'b1;
    cw.dac_ch = 2'h2;
    for (i = 0; i < 4; i++) begin
      cw.adc_ch = 2'(i);
      wctl;
      push(2);
      cyc(2);
      chk("adc drq", (i < 3) ? (1 << i) : 0, drq);
      if (i < 3) begin
        host_u.ack(2'(i));
        stat;
        chk("count after ack", 1, rd[CW+7:8]);
        host_u.ack(2'(i));
        cyc(2);
        chk("adc drq off", 0, drq);
      end
    end
    rst;
    cw.adc_ch = 2'h0;
    wctl;
    fire(4);
    cyc(2);
    chk("dac drq", 3'h4, drq);
    host_u.ack(2'h2);
    cyc(2);
    chk("dac drq off", 0, drq);
    cw.dual   = 1'b0;
    cw.adc_ch = 2'h1;
    wctl;
    fire(4);
    cyc(2);
    chk("single dac drq", 3'h2, drq);
    host_u.ack(2'h1);
    cyc(2);
    chk("single dac off", 0, drq);
    cw.dma_en = 1'b0;
    wctl;
    push(1);
    cyc(2);
    chk("dma off", 0, drq);
    $display("test dma done");
    finish_test;
  end

endmodule : hbi_top_tb

`default_nettype wire
